// ==== logic/nv_access.v ====
// eeprom access control: apb registers, arm window, write timer and array port
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "nv_access_defines.vh"
// How it works
// - setting write_strobe while master_write_arm is active starts programming the addressed byte.
// - writing one to read_strobe fetches the addressed byte into the data register.
// - the fetched byte is in the data register before the next bus access can complete.
// - a write in progress keeps running to completion when power-down is requested.
// - after such a write the timing oscillator stays running, so full power-down is not reached.
// - a reset during a write does not abort it; the timer carries on to completion.
// - master_write_arm clears itself four cycles after it is set; a write strobe without it does nothing.
// - write_strobe clears when the write time of 8448 oscillator cycles has run out.
// - with ready_irq_enable and global enable set, the ready request is high while write_strobe is zero.
// - during a write, read strobes are ignored and only a reset can change the address register.
module nv_access #(
   parameter integer WRITE_OSC_CYCLES = `WRITE_OSC_CYCLES,
   parameter integer OSC_DIV = `OSC_DIV
) (
   input wire clk_in,
   input wire srst_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   input wire [3:0] pstrb_in,
   output reg [31:0] prdata_out,
   output reg pready_out,
   output reg pslverr_out,
   output reg irq_out,
   output reg ready_irq_out,
   output reg power_down_out,
   output reg [8:0] array_addr_out,
   output reg [7:0] array_wdata_out,
   output reg array_write_out,
   output reg array_read_out,
   input wire [7:0] array_rdata_in
);
   localparam S_IDLE = 3'b001;
   localparam S_READ = 3'b010;
   localparam S_ANSWER = 3'b100;

   reg [2:0] state_r;
   reg [8:0] addr_r;
   reg [7:0] data_r;
   reg ready_irq_en_r;
   reg arm_r;
   reg [2:0] arm_cnt_r;
   reg busy_r;
   reg [13:0] osc_cnt_r;
   reg [7:0] div_r;
   reg done_tgl_r;
   reg done_s1_r;
   reg done_s2_r;
   reg done_s3_r;
   reg [1:0] status_r;
   reg [1:0] mask_r;
   reg pd_req_r;
   reg gie_r;
   reg osc_run_r;
   reg [31:0] rd_nxt;
   reg [1:0] status_nxt;
   wire access;
   wire wr;
   wire rd;
   wire osc_tick;
   wire done_evt;
   wire ctrl_wr;

   function sel;
      input [11:0] a;
      input [11:0] ofs;
      begin
         sel = (a == ofs);
      end
   endfunction

   function mapped;
      input [11:0] a;
      begin
         case (a)
            `OFS_ADDR_LOW, `OFS_ADDR_HIGH, `OFS_DATA, `OFS_CONTROL: begin
               mapped = 1'b1;
            end
            `OFS_IRQ_STATUS, `OFS_IRQ_MASK, `OFS_POWER: begin
               mapped = 1'b1;
            end
            default: begin
               mapped = 1'b0;
            end
         endcase
      end
   endfunction

   // held off while pready stands, so a request still held is not taken twice
   assign access = psel_in & penable_in & ~pready_out & (state_r == S_IDLE);
   assign wr = access & pwrite_in;
   assign rd = access & ~pwrite_in;
   assign ctrl_wr = wr & sel(paddr_in, `OFS_CONTROL) & pstrb_in[0];
   assign osc_tick = (div_r == 8'h00);
   // only the last two stages feed logic; the first is read by the second only
   assign done_evt = done_s2_r ^ done_s3_r;

   // oscillator emulated as an enable divider; kept running after a write
   always @(posedge clk_in) begin
      // an unknown count after power-up falls into the reset branch
      if (~srst_in | (osc_cnt_r != 14'h0000)) begin
         if (osc_tick) begin
            div_r <= OSC_DIV[7:0] - 8'h01;
         end else begin
            div_r <= div_r - 8'h01;
         end
      end else begin
         div_r <= 8'h00;
      end
   end

   // write timer: reset acts only once the count is zero, so a reset mid-write lets the write finish
   always @(posedge clk_in) begin
      if (~srst_in | (osc_cnt_r != 14'h0000)) begin
         if (ctrl_wr & pwdata_in[`BIT_WRITE_STROBE] & arm_r & ~busy_r) begin
            osc_cnt_r <= WRITE_OSC_CYCLES[13:0];
            osc_run_r <= 1'b1;
         end else if (osc_tick & (osc_cnt_r != 14'h0000)) begin
            osc_cnt_r <= osc_cnt_r - 14'h0001;
            if (osc_cnt_r == 14'h0001) begin
               done_tgl_r <= ~done_tgl_r;
            end
         end
      end else begin
         osc_cnt_r <= 14'h0000;
         done_tgl_r <= 1'b0;
         osc_run_r <= 1'b0;
      end
   end

   always @(posedge clk_in) begin
      done_s1_r <= done_tgl_r;
      done_s2_r <= done_s1_r;
      done_s3_r <= done_s2_r;
   end

   always @* begin
      rd_nxt = 32'h0000_0000;
      if (sel(paddr_in, `OFS_ADDR_LOW)) begin
         rd_nxt[7:0] = addr_r[7:0];
      end else if (sel(paddr_in, `OFS_ADDR_HIGH)) begin
         rd_nxt[0] = addr_r[8];
      end else if (sel(paddr_in, `OFS_DATA)) begin
         rd_nxt[7:0] = data_r;
      end else if (sel(paddr_in, `OFS_CONTROL)) begin
         rd_nxt[`BIT_READY_IRQ_EN] = ready_irq_en_r;
         rd_nxt[`BIT_MASTER_ARM] = arm_r;
         rd_nxt[`BIT_WRITE_STROBE] = busy_r;
      end else if (sel(paddr_in, `OFS_IRQ_STATUS)) begin
         rd_nxt[1:0] = status_r;
      end else if (sel(paddr_in, `OFS_IRQ_MASK)) begin
         rd_nxt[1:0] = mask_r;
      end else if (sel(paddr_in, `OFS_POWER)) begin
         rd_nxt[`BIT_POWER_DOWN_REQ] = pd_req_r;
         rd_nxt[`BIT_GLOBAL_IRQ_EN] = gie_r;
         rd_nxt[`BIT_OSC_RUNNING] = osc_run_r;
      end
   end

   always @* begin
      status_nxt = status_r;
      if (rd & sel(paddr_in, `OFS_IRQ_STATUS)) begin
         status_nxt = 2'h0;
      end
      // set after clear so a simultaneous event survives
      if (done_evt) begin
         status_nxt[`BIT_IRQ_WRITE_DONE] = 1'b1;
      end
      if (state_r == S_ANSWER) begin
         status_nxt[`BIT_IRQ_READ_DONE] = 1'b1;
      end
   end

   always @(posedge clk_in) begin
      if (srst_in) begin
         state_r <= S_IDLE;
         ready_irq_en_r <= `RST_READY_IRQ_EN;
         arm_r <= 1'b0;
         arm_cnt_r <= 3'h0;
         status_r <= `RST_MASK;
         mask_r <= `RST_MASK;
         pd_req_r <= 1'b0;
         gie_r <= 1'b0;
         prdata_out <= 32'h0000_0000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         irq_out <= 1'b0;
         ready_irq_out <= 1'b0;
         power_down_out <= 1'b0;
         array_write_out <= 1'b0;
         array_read_out <= 1'b0;
         array_addr_out <= 9'h000;
         array_wdata_out <= 8'h00;
         addr_r <= 9'h000;
         data_r <= 8'h00;
      end else begin
         status_r <= status_nxt;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         array_write_out <= 1'b0;
         array_read_out <= 1'b0;
         if (arm_r) begin
            arm_cnt_r <= arm_cnt_r - 3'h1;
            if (arm_cnt_r == 3'h1) begin
               arm_r <= 1'b0;
            end
         end
         case (state_r)
            S_IDLE: begin
               if (access) begin
                  pready_out <= 1'b1;
                  prdata_out <= rd_nxt;
                  pslverr_out <= ~mapped(paddr_in);
               end
               if (wr & pstrb_in[0]) begin
                  if (sel(paddr_in, `OFS_ADDR_LOW) & ~busy_r) begin
                     addr_r[7:0] <= pwdata_in[7:0];
                  end
                  if (sel(paddr_in, `OFS_ADDR_HIGH) & ~busy_r) begin
                     addr_r[8] <= pwdata_in[0];
                  end
                  if (sel(paddr_in, `OFS_DATA)) begin
                     data_r <= pwdata_in[7:0];
                  end
                  if (sel(paddr_in, `OFS_IRQ_MASK)) begin
                     mask_r <= pwdata_in[1:0];
                  end
                  if (sel(paddr_in, `OFS_POWER)) begin
                     pd_req_r <= pwdata_in[`BIT_POWER_DOWN_REQ];
                     gie_r <= pwdata_in[`BIT_GLOBAL_IRQ_EN];
                  end
               end
               if (ctrl_wr) begin
                  ready_irq_en_r <= pwdata_in[`BIT_READY_IRQ_EN];
                  if (pwdata_in[`BIT_MASTER_ARM] & ~pwdata_in[`BIT_WRITE_STROBE]) begin
                     arm_r <= 1'b1;
                     arm_cnt_r <= `ARM_CYCLES;
                  end
                  if (pwdata_in[`BIT_WRITE_STROBE] & arm_r & ~busy_r) begin
                     array_write_out <= 1'b1;
                     array_addr_out <= addr_r;
                     array_wdata_out <= data_r;
                     arm_r <= 1'b0;
                  end else if (pwdata_in[`BIT_READ_STROBE] & ~busy_r) begin
                     // pready held back until the byte is in, so the next read sees it
                     pready_out <= 1'b0;
                     array_read_out <= 1'b1;
                     array_addr_out <= addr_r;
                     state_r <= S_READ;
                  end
               end
            end
            S_READ: begin
               state_r <= S_ANSWER;
            end
            S_ANSWER: begin
               data_r <= array_rdata_in;
               pready_out <= 1'b1;
               prdata_out <= 32'h0000_0000;
               state_r <= S_IDLE;
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
         irq_out <= |(status_nxt & mask_r);
         ready_irq_out <= ready_irq_en_r & gie_r & ~busy_r;
         // power-down waits for the write; afterwards the oscillator keeps it partial
         power_down_out <= pd_req_r & ~busy_r & ~osc_run_r;
      end
   end

   // busy follows the synchronised completion, never the raw timer; reset drops it only while osc_run_r is low
   always @(posedge clk_in) begin
      if (ctrl_wr & pwdata_in[`BIT_WRITE_STROBE] & arm_r & ~busy_r & (state_r == S_IDLE)) begin
         busy_r <= 1'b1;
      end else if (done_evt) begin
         busy_r <= 1'b0;
      end else if (srst_in & ~osc_run_r) begin
         busy_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== logic/nv_access_defines.vh ====
// register offsets, field positions, reset values and timing counts of the eeprom access block
`ifndef NV_ACCESS_DEFINES_VH
`define NV_ACCESS_DEFINES_VH
`define OFS_ADDR_LOW 12'h000
`define OFS_ADDR_HIGH 12'h004
`define OFS_DATA 12'h008
`define OFS_CONTROL 12'h00c
`define OFS_IRQ_STATUS 12'h010
`define OFS_IRQ_MASK 12'h014
`define OFS_POWER 12'h018
`define BIT_READ_STROBE 0
`define BIT_WRITE_STROBE 1
`define BIT_MASTER_ARM 2
`define BIT_READY_IRQ_EN 3
`define BIT_IRQ_WRITE_DONE 0
`define BIT_IRQ_READ_DONE 1
`define BIT_POWER_DOWN_REQ 0
`define BIT_GLOBAL_IRQ_EN 1
`define BIT_OSC_RUNNING 2
`define RST_CONTROL 8'h00
`define RST_MASK 2'h0
`define RST_READY_IRQ_EN 1'b0
`define ARM_CYCLES 3'h4
`define WRITE_OSC_CYCLES 8448
`define OSC_FREQ_HZ 1000000
`define CLK_FREQ_HZ 125000000
`define OSC_DIV (`CLK_FREQ_HZ / `OSC_FREQ_HZ)
`endif

// ==== dv/nv_access_monitor.sv ====
// concurrent checks on the eeprom access block ports
`timescale 1ns/1ns
`default_nettype none
module nv_access_monitor #(
   parameter integer WRITE_OSC_CYCLES = 4,
   parameter integer OSC_DIV = 2
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic ready_irq_out,
   input wire logic power_down_out,
   input wire logic [8:0] array_addr_out,
   input wire logic array_write_out,
   input wire logic array_read_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);
   sequence s_ctrl_acc;
      psel_in && penable_in && pwrite_in && paddr_in == 12'h00c;
   endsequence
   sequence s_read_done;
      ##2 pready_out;
   endsequence
   a_pready_pulse: assert property (pready_out |=> !pready_out) else $error("pready too long");
   a_pready_cause: assert property (pready_out |-> $past(psel_in && penable_in))
      else $error("pready without access");
   a_slverr_ready: assert property (pslverr_out |-> pready_out) else $error("lone slverr");
   a_write_cause: assert property (array_write_out |-> $past(pwdata_in[1] && psel_in && penable_in
      && pwrite_in && paddr_in == 12'h00c)) else $error("array write without strobe");
   a_read_cause: assert property (array_read_out |-> $past(pwdata_in[0] && psel_in && penable_in
      && pwrite_in && paddr_in == 12'h00c)) else $error("array read without strobe");
   a_ctrl_answer: assert property (s_ctrl_acc ##0 (!pready_out && !pwdata_in[0]) |=> pready_out)
      else $error("control write unanswered");
   a_read_ready: assert property (array_read_out |-> s_read_done) else $error("read answer late");
   a_ready_irq_busy: assert property (array_write_out |-> ##2 !ready_irq_out)
      else $error("ready irq during write");
   a_addr_hold: assert property (array_write_out |=> $stable(array_addr_out) [*8])
      else $error("address moved during write");
   a_no_pd_busy: assert property (array_write_out |=> !power_down_out [*8])
      else $error("power down during write");
endmodule
bind nv_access nv_access_monitor #(.WRITE_OSC_CYCLES(WRITE_OSC_CYCLES), .OSC_DIV(OSC_DIV)) mon (
   .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .ready_irq_out(ready_irq_out), .power_down_out(power_down_out),
   .array_addr_out(array_addr_out), .array_write_out(array_write_out),
   .array_read_out(array_read_out));
`default_nettype wire

// ==== dv/nv_array_model.sv ====
// behavioural eeprom array on the far side of the block
`timescale 1ns/1ns
`default_nettype none
module nv_array_model (
   input wire logic clk_in,
   input wire logic [8:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic write_in,
   input wire logic read_in,
   output logic [7:0] rdata_out
);
   logic [7:0] mem [0:511];
   int hold;
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      rdata_out = 8'h00;
      hold = 0;
   end
   // data is only valid for the hold time; otherwise it toggles so stale reads show
   always @(posedge clk_in) begin
      if (write_in) mem[addr_in] <= wdata_in;
      if (read_in) begin
         rdata_out <= mem[addr_in];
         hold <= 3;
      end else if (hold > 0) hold <= hold - 1;
      else rdata_out <= ~rdata_out;
   end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the eeprom access block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk_in = 0, srst_in = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, rdy;
   logic pd, awr, ard, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [8:0] aaddr;
   logic [7:0] awd, ard_d;
   int mismatches = 0, n_checks = 0, n_rd = 0;
   nv_access #(.WRITE_OSC_CYCLES(4), .OSC_DIV(2)) DUT (.clk_in(clk_in), .srst_in(srst_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .irq_out(irq), .ready_irq_out(rdy), .power_down_out(pd),
      .array_addr_out(aaddr), .array_wdata_out(awd), .array_write_out(awr),
      .array_read_out(ard), .array_rdata_in(ard_d));
   nv_array_model mdl (.clk_in(clk_in), .addr_in(aaddr), .wdata_in(awd), .write_in(awr),
      .read_in(ard), .rdata_out(ard_d));
   initial forever #4 clk_in = ~clk_in;
   always @(posedge clk_in) if (ard) n_rd++;
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // full apb transfer; the answer is taken only at the edge that samples pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_in);
      penable <= 1;
      i = 0;
      do begin @(posedge clk_in); i++; end while (pready !== 1'b1 && i < 50);
      rd = prdata; err = pslverr;
      if (i >= 50) begin mismatches++; complete_run; end
      psel <= 0; penable <= 0;
      @(posedge clk_in);
   endtask
   task automatic wait_idle;
      int i;
      for (i = 0; i < 100; i++) begin
         apb(0, 12'h00c, 0);
         if (rd[1] === 1'b0) return;
      end
      mismatches++;
      complete_run;
   endtask
   task automatic nv_write(input logic [8:0] a, input logic [7:0] d);
      apb(1, 12'h004, {31'h0, a[8]});
      apb(1, 12'h000, {24'h0, a[7:0]});
      apb(1, 12'h008, {24'h0, d});
      apb(1, 12'h00c, 32'h0c);
      apb(1, 12'h00c, 32'h0a);
   endtask
   task automatic t_regs;
      apb(0, 12'h00c, 0); chk("control", 32'h0, rd);
      apb(0, 12'h014, 0); chk("mask", 32'h0, rd);
      apb(0, 12'h01c, 0); chk("unmapped err", 1, err);
      chk("unmapped data", 32'h0, rd);
      apb(1, 12'h018, 32'h1); chk("pd idle", 1, pd);
      apb(1, 12'h018, 32'h0); chk("pd off", 0, pd);
   endtask
   task automatic t_write_read;
      apb(1, 12'h018, 32'h2); apb(1, 12'h014, 32'h1); apb(1, 12'h00c, 32'h08);
      chk("ready irq idle", 1, rdy);
      nv_write(9'h123, 8'ha5);
      chk("ready irq busy", 0, rdy);
      apb(1, 12'h000, 32'h55); apb(1, 12'h00c, 32'h09);
      chk("read while busy", 0, n_rd);
      wait_idle();
      chk("stored", 8'ha5, mdl.mem[9'h123]);
      chk("irq", 1, irq);
      apb(0, 12'h010, 0); chk("status", 32'h1, rd);
      apb(0, 12'h010, 0); chk("status clear", 32'h0, rd);
      chk("irq clear", 0, irq);
      apb(1, 12'h00c, 32'h09); apb(0, 12'h008, 0);
      chk("read back", 32'ha5, rd);
   endtask
   task automatic t_guard;
      apb(1, 12'h008, 32'h77);
      apb(1, 12'h00c, 32'h0a); apb(0, 12'h00c, 0); chk("unarmed", 0, rd[1]);
      apb(1, 12'h00c, 32'h0e); apb(0, 12'h00c, 0); chk("same word", 0, rd[1]);
      apb(1, 12'h00c, 32'h0c); repeat (3) @(posedge clk_in);
      apb(1, 12'h00c, 32'h0a); apb(0, 12'h00c, 0); chk("expired", 0, rd[1]);
      chk("array kept", 8'ha5, mdl.mem[9'h123]);
   endtask
   task automatic t_power_reset;
      nv_write(9'h040, 8'h3c);
      apb(1, 12'h018, 32'h3);
      chk("pd busy", 0, pd);
      wait_idle();
      chk("pd write", 8'h3c, mdl.mem[9'h040]);
      apb(0, 12'h018, 0); chk("osc on", 1, rd[2]);
      chk("no full pd", 0, pd);
      apb(1, 12'h018, 32'h0);
      nv_write(9'h000, 8'hc3);
      srst_in <= 1; repeat (2) @(posedge clk_in); srst_in <= 0; @(posedge clk_in);
      apb(0, 12'h00c, 0); chk("busy across reset", 1, rd[1]);
      wait_idle();
      chk("write across reset", 8'hc3, mdl.mem[9'h000]);
   endtask
   initial begin
      repeat (20) @(posedge clk_in);
      srst_in <= 0;
      @(posedge clk_in);
      t_regs();
      t_write_read();
      t_guard();
      t_power_reset();
      complete_run();
   end
endmodule
`default_nettype wire
